// *** common/ssw_pkg.sv ***
// constants, timing and state type for the supply supervisor watchdog
package ssw_pkg;
  localparam int CLK_PERIOD_NS       = 25;
  // internal oscillator tick period, one millisecond
  localparam int INT_TICK_PERIOD_NS  = 1000000;
  localparam int INT_TICK_CYCLES     = (INT_TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_TICK_MS         = 1;
  localparam int RESET_HOLD_MS       = 50;
  localparam int TB_CNT_W            = 16;
  localparam int CNT_W               = 11;
  localparam logic [CNT_W-1:0] HOLD_TICKS = CNT_W'(RESET_HOLD_MS / INT_TICK_MS);
  // watchdog timeout in time-base ticks, plain default
  localparam logic [CNT_W-1:0] WDT_TICKS  = 11'h3E8;
  localparam logic [CNT_W-1:0] CNT_ONE    = 11'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 11'h000;

  // synchroniser lanes
  localparam int NUM_PINS   = 8;
  localparam int PIN_LL     = 0;
  localparam int PIN_BELOW  = 1;
  localparam int PIN_PF     = 2;
  localparam int PIN_WD_HI  = 3;
  localparam int PIN_WD_LO  = 4;
  localparam int PIN_SEL    = 5;
  localparam int PIN_OSC    = 6;
  localparam int PIN_CS_N   = 7;
  // select pulled high and chip-select idle high while in reset
  localparam logic [NUM_PINS-1:0] SYNC_RESET_VAL = 8'hA0;

  typedef enum logic [1:0] {
    SSW_LOW,
    SSW_HOLD,
    SSW_RUN,
    SSW_WDPULSE
  } ssw_state_t;
endpackage

// *** common/ssw_tick_if.sv ***
// time-base select, external clock level and tick between top and time base
`timescale 1ns/100ps
interface ssw_tick_if;
  logic use_external;
  logic ext_level;
  logic tick;
  modport src (input use_external, input ext_level, output tick);
  modport dst (output use_external, output ext_level, input tick);
endinterface

// *** verilog/ssw_timebase.sv ***
// time base: internal divider or edges of the external time-base input
`timescale 1ns/100ps
module ssw_timebase #(
  parameter int TICK_CYCLES = ssw_pkg::INT_TICK_CYCLES
) (
  input  wire logic  clk_in,
  input  wire logic  nrst_in,
  ssw_tick_if.src    tb
);
  import ssw_pkg::*;

  logic [TB_CNT_W-1:0] div_cnt;
  logic                ext_prev;
  logic                div_wrap;
  logic                ext_rise;

  assign div_wrap = (div_cnt == TB_CNT_W'(TICK_CYCLES - 1));
  // input already passed two flops in the top, safe to edge-detect here
  assign ext_rise = tb.ext_level & ~ext_prev;
  assign tb.tick  = tb.use_external ? ext_rise : div_wrap;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt  <= '0;
      ext_prev <= 1'b0;
    end else begin
      div_cnt  <= (div_wrap || tb.use_external) ? '0 : div_cnt + 1'b1;
      ext_prev <= tb.ext_level;
    end
  end

  a_ext_tick_src: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (tb.use_external && !(tb.ext_level && !ext_prev)) |-> !tb.tick)
    else $error("tick without external edge while external source selected");
endmodule

// *** verilog/ssw_top.sv ***
// supply supervisor: reset sequencing, three-level watchdog, status flags, chip-select gate
`timescale 1ns/100ps
module ssw_top #(
  parameter int INT_TICK_CYCLES = ssw_pkg::INT_TICK_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic low_line_sense_in,
  input  wire logic supply_below_backup_in,
  input  wire logic power_fail_sense_in,
  input  wire logic watchdog_strobe_hi_in,
  input  wire logic watchdog_strobe_lo_in,
  input  wire logic timebase_source_select_in,
  input  wire logic timebase_input_in,
  input  wire logic chip_select_n_in,
  output logic      reset_n_out,
  output logic      reset_out,
  output logic      watchdog_fault_n_out,
  output logic      power_fail_flag_n_out,
  output logic      backup_active_flag_out,
  output logic      low_line_flag_n_out,
  output logic      chip_select_n_out
);
  import ssw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [NUM_PINS-1:0] pins_raw;
  wire  [NUM_PINS-1:0] sync_b;

  assign pins_raw = {chip_select_n_in, timebase_input_in, timebase_source_select_in,
                     watchdog_strobe_lo_in, watchdog_strobe_hi_in, power_fail_sense_in,
                     supply_below_backup_in, low_line_sense_in};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      // one flop pair per lane keeps each register owned by a single process
      logic stage_a;
      logic stage_b;
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          stage_a <= SYNC_RESET_VAL[gi];
          stage_b <= SYNC_RESET_VAL[gi];
        end else begin
          stage_a <= pins_raw[gi];
          stage_b <= stage_a;
        end
      end
      assign sync_b[gi] = stage_b;
    end
  endgenerate

  logic line_ok;
  logic below_backup;
  logic supply_low;
  assign line_ok      = sync_b[PIN_LL];
  assign below_backup = sync_b[PIN_BELOW];
  assign supply_low   = ~line_ok | below_backup;

  ////////////////////////////////////////////////////////////////////////////
  // time base
  ssw_tick_if tbi ();
  assign tbi.use_external = ~sync_b[PIN_SEL];
  assign tbi.ext_level    = sync_b[PIN_OSC];

  ssw_timebase #(
    .TICK_CYCLES (INT_TICK_CYCLES)
  ) u_timebase (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .tb      (tbi.src)
  );

  logic tick;
  assign tick = tbi.tick;

  ////////////////////////////////////////////////////////////////////////////
  // three-level strobe decode
  logic strobe_hi;
  logic strobe_lo;
  logic wd_enabled;
  logic last_level;
  logic strobe_edge;
  assign strobe_hi   = sync_b[PIN_WD_HI] & ~sync_b[PIN_WD_LO];
  assign strobe_lo   = sync_b[PIN_WD_LO] & ~sync_b[PIN_WD_HI];
  assign wd_enabled  = strobe_hi | strobe_lo;
  // a change between solid high and solid low counts; mid-level is not a level
  assign strobe_edge = wd_enabled & (strobe_hi != last_level);

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer and watchdog timer
  ssw_state_t       state;
  ssw_state_t       next_state;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] next_hold_cnt;
  logic [CNT_W-1:0] wd_cnt;
  logic             wd_expire;
  logic             wd_clear;
  logic             hold_done;

  // timer only runs while the host is out of reset
  assign wd_clear  = strobe_edge | ~wd_enabled | (state != SSW_RUN);
  assign wd_expire = ~wd_clear & tick & (wd_cnt == WDT_TICKS - CNT_ONE);
  assign hold_done = tick & (hold_cnt == HOLD_TICKS - CNT_ONE);

  always_comb begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    if (supply_low) begin
      next_state    = SSW_LOW;
      next_hold_cnt = CNT_ZERO;
    end else begin
      case (state)
        SSW_LOW: begin
          next_state    = SSW_HOLD;
          next_hold_cnt = CNT_ZERO;
        end
        SSW_HOLD, SSW_WDPULSE: begin
          if (hold_done) begin
            next_state    = SSW_RUN;
            next_hold_cnt = CNT_ZERO;
          end else if (tick) begin
            next_hold_cnt = hold_cnt + CNT_ONE;
          end
        end
        SSW_RUN: begin
          if (wd_expire) begin
            next_state    = SSW_WDPULSE;
            next_hold_cnt = CNT_ZERO;
          end
        end
        default: begin
          next_state    = SSW_LOW;
          next_hold_cnt = CNT_ZERO;
        end
      endcase
    end
  end

  logic next_fault_n;
  // recovery wins over a new expiry in the same cycle
  assign next_fault_n = (strobe_edge | ~line_ok) ? 1'b1 :
                        wd_expire ? 1'b0 : watchdog_fault_n_out;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state    <= SSW_LOW;
      hold_cnt <= CNT_ZERO;
      wd_cnt   <= CNT_ZERO;
      last_level <= 1'b0;
    end else begin
      state    <= next_state;
      hold_cnt <= next_hold_cnt;
      if (wd_clear || wd_expire) begin
        wd_cnt <= CNT_ZERO;
      end else if (tick) begin
        wd_cnt <= wd_cnt + CNT_ONE;
      end
      if (wd_enabled) begin
        last_level <= strobe_hi;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_n_out            <= 1'b0;
      reset_out              <= 1'b1;
      watchdog_fault_n_out   <= 1'b1;
      power_fail_flag_n_out  <= 1'b0;
      backup_active_flag_out <= 1'b0;
      low_line_flag_n_out    <= 1'b0;
      chip_select_n_out      <= 1'b1;
    end else begin
      reset_n_out            <= (next_state == SSW_RUN);
      reset_out              <= (next_state != SSW_RUN);
      watchdog_fault_n_out   <= next_fault_n;
      power_fail_flag_n_out  <= sync_b[PIN_PF] & ~below_backup;
      backup_active_flag_out <= below_backup;
      low_line_flag_n_out    <= line_ok;
      chip_select_n_out      <= line_ok ? sync_b[PIN_CS_N] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_recover;
    supply_low ##1 !supply_low;
  endsequence

  sequence s_expire;
    wd_expire;
  endsequence

  a_reset_on_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    supply_low |=> !reset_n_out && reset_out)
    else $error("reset not asserted on low supply");
  a_hold_after_recover: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_recover |=> !reset_n_out [*2])
    else $error("reset released without hold delay");
  a_wd_pulse_start: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (s_expire and !supply_low) |=> !reset_n_out && (state == SSW_WDPULSE))
    else $error("watchdog expiry did not pulse reset");
  a_wd_fault_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (s_expire and !supply_low) |=> !watchdog_fault_n_out)
    else $error("fault flag not low after expiry");
  a_strobe_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
    strobe_edge |=> (wd_cnt == CNT_ZERO) && watchdog_fault_n_out)
    else $error("strobe transition did not restart watchdog");
  a_mid_disabled: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !wd_enabled [*2] |-> (wd_cnt == CNT_ZERO) && !wd_expire)
    else $error("watchdog running with mid-level strobe");
  a_pf_follow: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (sync_b[PIN_PF] && !below_backup) |=> power_fail_flag_n_out)
    else $error("power-fail flag low with good sense");
  a_pf_backup: assert property (@(posedge clk_in) disable iff (!nrst_in)
    below_backup |=> !power_fail_flag_n_out && backup_active_flag_out)
    else $error("power-fail flag not forced on backup");
  a_cs_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !line_ok |=> chip_select_n_out && !low_line_flag_n_out)
    else $error("chip-select not blocked on low line");
  a_ll_recover: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(line_ok) |=> low_line_flag_n_out)
    else $error("low-line flag late on recovery");
  a_reset_inverse: assert property (@(posedge clk_in) disable iff (!nrst_in)
    reset_out != reset_n_out)
    else $error("reset outputs not complementary");
endmodule

// *** tb/ssw_host_model.sv ***
// host model: services the watchdog strobe and drives the memory chip-select
`timescale 1ns/100ps
module ssw_host_model #(
  parameter int TOGGLE_CYCLES = 100
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       cs_req_in,
  output logic            strobe_hi_out,
  output logic            strobe_lo_out,
  output logic            chip_select_n_out
);
  int   cnt;
  logic level;

  ////////////////////////////////////////////////////////////
  // mode 0 floating, 1 serviced, 2 stuck high, 3 stuck low
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt   <= 0;
      level <= 1'b0;
    end else if (cnt == TOGGLE_CYCLES - 1) begin
      cnt   <= 0;
      level <= ~level;
    end else begin
      cnt <= cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////
  // floating shows as neither comparator set
  assign strobe_hi_out     = (mode_in == 2'h1) ? level : (mode_in == 2'h2);
  assign strobe_lo_out     = (mode_in == 2'h1) ? ~level : (mode_in == 2'h3);
  assign chip_select_n_out = ~cs_req_in;
endmodule

// *** tb/ssw_tb_top.sv ***
// self-checking bench for the supply supervisor watchdog
`timescale 1ns/100ps
module ssw_tb_top;
  import ssw_pkg::*;
  logic       clk_in, nrst_in, ll, below, pf, sel, cs_req;
  logic       osc = 1'b0;
  logic [1:0] mode;
  int         osc_cnt = 0;
  int         n_fail, n_compared;
  wire        wd_hi, wd_lo, cs_n, rst_n, rst, fault_n, pf_n, batt, ll_n, cs_out;
  wire [1:0]  obs = {fault_n, rst_n};

  ssw_top #(.INT_TICK_CYCLES(4)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .low_line_sense_in(ll), .supply_below_backup_in(below),
    .power_fail_sense_in(pf), .watchdog_strobe_hi_in(wd_hi), .watchdog_strobe_lo_in(wd_lo),
    .timebase_source_select_in(sel), .timebase_input_in(osc), .chip_select_n_in(cs_n),
    .reset_n_out(rst_n), .reset_out(rst), .watchdog_fault_n_out(fault_n),
    .power_fail_flag_n_out(pf_n), .backup_active_flag_out(batt), .low_line_flag_n_out(ll_n),
    .chip_select_n_out(cs_out));

  ssw_host_model host (
    .clk_in(clk_in), .nrst_in(nrst_in), .mode_in(mode), .cs_req_in(cs_req),
    .strobe_hi_out(wd_hi), .strobe_lo_out(wd_lo), .chip_select_n_out(cs_n));

  ////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // external time base: one rising edge every 8 clocks
  always @(posedge clk_in) begin
    osc_cnt <= osc_cnt + 1;
    osc     <= osc_cnt[2];
  end

  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic chk_rst(input logic rn);
    chk("reset_n_out", rn, rst_n);
    chk("reset_out", ~rn, rst);
  endtask

  // bounded wait on reset_n (0) or fault_n (1); early or late both count
  task automatic wait_out(input int which, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (obs[which] !== v && n < hi) begin
      @(negedge clk_in);
      n++;
    end
    chk("wait level", v, obs[which]);
    if (n < lo) chk("wait too early", 1'b0, 1'b1);
    if (obs[which] !== v) tally_and_finish();
  endtask

  task automatic set_ll(input logic v);
    @(posedge clk_in);
    ll <= v;
    idle(4);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_low_line();
    set_ll(1'b0);
    chk_rst(1'b0);
    chk("low_line_flag_n_out", 1'b0, ll_n);
    chk("chip_select_n_out", 1'b1, cs_out);
    set_ll(1'b1);
    chk("low_line_flag_n_out", 1'b1, ll_n);
    chk("chip_select_n_out", 1'b0, cs_out);
    chk_rst(1'b0);
    wait_out(0, 1'b1, 185, 215);
    chk_rst(1'b1);
  endtask

  task automatic t_backup();
    @(posedge clk_in);
    below <= 1'b1;
    idle(4);
    chk_rst(1'b0);
    chk("power_fail_flag_n_out", 1'b0, pf_n);
    chk("backup_active_flag_out", 1'b1, batt);
    @(posedge clk_in);
    below <= 1'b0;
    idle(4);
    chk("power_fail_flag_n_out", 1'b1, pf_n);
    chk("backup_active_flag_out", 1'b0, batt);
    wait_out(0, 1'b1, 185, 215);
  endtask

  task automatic t_power_fail();
    @(posedge clk_in);
    pf     <= 1'b0;
    cs_req <= 1'b0;
    idle(4);
    chk("power_fail_flag_n_out", 1'b0, pf_n);
    chk("chip_select_n_out", 1'b1, cs_out);
    @(posedge clk_in);
    pf     <= 1'b1;
    cs_req <= 1'b1;
    idle(4);
    chk("power_fail_flag_n_out", 1'b1, pf_n);
    chk("chip_select_n_out", 1'b0, cs_out);
  endtask

  task automatic t_no_reset(input logic [1:0] m);
    logic ok;
    ok = 1'b1;
    @(posedge clk_in);
    mode <= m;
    repeat (4500) begin
      @(negedge clk_in);
      if (rst_n !== 1'b1 || fault_n !== 1'b1) ok = 1'b0;
    end
    chk("no watchdog reset", 1'b1, ok);
  endtask

  task automatic t_stuck();
    @(posedge clk_in);
    mode <= 2'h2;
    wait_out(1, 1'b0, 3880, 4120);
    chk_rst(1'b0);
    wait_out(0, 1'b1, 190, 215);
    @(posedge clk_in);
    mode <= 2'h1;
    wait_out(1, 1'b1, 0, 110);
    @(posedge clk_in);
    mode <= 2'h3;
    wait_out(1, 1'b0, 3880, 4120);
    set_ll(1'b0);
    idle(1);
    chk("watchdog_fault_n_out", 1'b1, fault_n);
    @(posedge clk_in);
    mode <= 2'h1;
    set_ll(1'b1);
    wait_out(0, 1'b1, 185, 215);
  endtask

  // slower external ticks double the hold time
  task automatic t_external();
    @(posedge clk_in);
    sel <= 1'b0;
    set_ll(1'b0);
    set_ll(1'b1);
    wait_out(0, 1'b1, 385, 420);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    nrst_in    = 1'b0;
    ll         = 1'b1;
    below      = 1'b0;
    pf         = 1'b1;
    sel        = 1'b1;
    cs_req     = 1'b1;
    mode       = 2'h1;
    n_fail     = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    idle(1);
    chk_rst(1'b0);
    wait_out(0, 1'b1, 190, 220);
    t_low_line();
    t_backup();
    t_power_fail();
    t_no_reset(2'h1);
    t_no_reset(2'h0);
    t_stuck();
    t_external();
    tally_and_finish();
  end
endmodule
